/* ctq_pkg.sv */
package ctq_pkg;

    // Register byte addresses on the APB slave
    localparam logic [7:0] CTQ_OFS_BASE = 8'h00;
    localparam logic [7:0] CTQ_OFS_CTRL = 8'h04;
    localparam logic [7:0] CTQ_OFS_MODE = 8'h08;
    localparam logic [7:0] CTQ_OFS_STAT = 8'h0C;

    // Queue control field positions
    localparam int CTQ_PLD_LSB = 29;
    localparam int CTQ_DEPTH_LSB = 24;
    localparam int CTQ_RETRY_LSB = 21;
    localparam int CTQ_PRIO_LSB = 16;
    localparam int CTQ_CLEAR_BIT = 10;
    localparam int CTQ_SEND_BIT = 9;
    localparam int CTQ_ADV_BIT = 8;
    localparam int CTQ_TXDIR_BIT = 7;
    localparam int CTQ_ATIE_BIT = 4;
    localparam int CTQ_QEIE_BIT = 2;
    localparam int CTQ_QNIE_BIT = 0;

    // Mode register fields (mirror of the controller main control layout)
    localparam int CTQ_OPMODE_LSB = 21;
    localparam int CTQ_RLEN_BIT = 8;

    // Status register fields
    localparam int CTQ_IDX_LSB = 8;
    localparam int CTQ_EXH_BIT = 4;
    localparam int CTQ_EMPTY_BIT = 2;
    localparam int CTQ_NFULL_BIT = 0;

    // Encodings and reset values
    localparam logic [2:0] CTQ_OPMODE_CONFIG = 3'h4;
    localparam logic [2:0] CTQ_OPMODE_RST = 3'h4;
    localparam logic [1:0] CTQ_RETRY_NONE = 2'h0;
    localparam logic [1:0] CTQ_RETRY_THREE = 2'h1;
    localparam logic [1:0] CTQ_RETRY_RST = 2'h3;
    localparam logic [1:0] CTQ_THREE_RETRIES = 2'h3;
    localparam logic [31:0] CTQ_BASE_RST = 32'h0000_0000;
    localparam logic [31:0] CTQ_BASE_MASK = 32'hFFFF_FFFC;

    // Message object header size in bytes ahead of the payload
    localparam logic [7:0] CTQ_HDR_BYTES = 8'h08;

    // Request towards the CAN FD transmit engine
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [4:0] prio;
        logic [1:0] retry_sel;
    } ctq_tx_req_s;

endpackage

/* ctq_tx_queue.sv */
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps

// Operation
// - Base address marks event FIFO start; message objects follow it. The code has no event FIFO and places object 0 at the base address itself.
// - Base address bits 1:0 always read zero.
// - Base address writable only when op mode equals configuration (100).
// - Payload select bits 31-29 map to 8,12,16,20,24,32,48,64 bytes.
// - Depth select gives value plus one messages, 1 to 32.
// - Payload and depth selects writable only in configuration mode.
// - Retry limit: 00 none, 01 three, 1x unlimited; resets to 11.
// - Retry limit applies only while retry limit enable bit is set.
// - Retry limit stays writable in normal mode.
// - Priority field bits 20-16 sets internal arbitration priority.
// - Queue clear reads set in configuration mode, clears in normal mode.
// - Writing 1 to queue clear resets queue; hardware clears when done.
// - Send request starts sending; self clears when all messages sent.
// - Writing 0 to a set send request asks for an abort.
// - Head advance moves the head pointer by exactly one message.
// - Transmit direction bit 7 is read only and reads 1.
// - Bit 4 enables the retries exhausted interrupt.
// - Bit 2 enables the queue empty interrupt.
// - Bit 0 enables the queue not full interrupt.
// - Unimplemented control bits 23, 15-11, 6-5, 3, 1 read zero.
// - Priority 11111 is highest, 00000 lowest.
// - Empty flag reads 1 with no message queued, else 0.
// - Not full flag reads 1 while space remains, 0 when full.
module ctq_tx_queue
    import ctq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit engine side
    output ctq_tx_req_s tx_req,
    output logic tx_abort,
    input wire logic tx_done,
    input wire logic tx_fail,
    // Queue interrupt request
    output logic queue_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    //
    // Both helpers are pure decodes shared by the address and pointer logic.
    // Keeping them as functions means the object size and the wrap point are
    // computed the same way everywhere they are needed.

    // Payload bytes per message for a 3-bit select
    function automatic logic [7:0] payload_bytes(input logic [2:0] sel);
        case (sel)
            3'h0: payload_bytes = 8'h08;
            3'h1: payload_bytes = 8'h0C;
            3'h2: payload_bytes = 8'h10;
            3'h3: payload_bytes = 8'h14;
            3'h4: payload_bytes = 8'h18;
            3'h5: payload_bytes = 8'h20;
            3'h6: payload_bytes = 8'h30;
            default: payload_bytes = 8'h40;
        endcase
    endfunction

    // Next pointer, wrapping at the configured depth
    // The depth select is the last valid index, so a select of zero gives a
    // one-entry queue whose pointer never moves away from zero.
    function automatic logic [4:0] ptr_inc(input logic [4:0] ptr, input logic [4:0] depth_sel);
        ptr_inc = (ptr == depth_sel) ? 5'h00 : ptr + 5'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    //
    // Software visible fields keep the names they carry in the register map.
    // Head and count are private, tail reads back as the status index; count is one bit wider than the
    // pointers so that a full 32-deep queue can be told from an empty one.

    logic [31:0] msg_mem_base_addr_r;
    logic [2:0] payload_bytes_sel_r;
    logic [4:0] queue_depth_sel_r;
    logic [1:0] retry_limit_sel_r;
    logic [4:0] send_priority_r;
    logic queue_clear_r;
    logic send_request_r;
    logic retries_exhausted_irq_en_r;
    logic queue_empty_irq_en_r;
    logic queue_not_full_irq_en_r;
    logic [2:0] op_mode_state_r;
    logic retry_limit_enable_r;
    logic retries_exhausted_r;
    logic [4:0] head_r;
    logic [4:0] tail_r;
    logic [5:0] count_r;
    logic [1:0] fail_cnt_r;

    logic config_mode;
    logic wr_en;
    logic rd_setup;
    logic wr_ctrl;
    logic adv_req;
    logic queue_empty_flag;
    logic queue_not_full_flag;
    logic give_up;
    logic pop;
    logic push;
    logic [5:0] depth_msgs;
    logic [7:0] obj_bytes;
    logic [11:0] obj_offset;
    logic [31:0] ctrl_rd;

    // Decoded bus strobes and queue flags
    // All of these are combinational views of registered state, of the bus
    // or of the engine handshake; none of them is an output, so the outputs stay glitch free.
    assign config_mode = (op_mode_state_r == CTQ_OPMODE_CONFIG);
    // Writes take effect at the access edge, where pready is already high
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_ctrl = wr_en & (paddr == CTQ_OFS_CTRL);
    assign adv_req = wr_ctrl & pwdata[CTQ_ADV_BIT];
    assign depth_msgs = {1'b0, queue_depth_sel_r} + 6'h01;
    assign queue_empty_flag = (count_r == 6'h00);
    assign queue_not_full_flag = (count_r < depth_msgs);
    // A failed attempt ends the message once the limit is spent
    assign give_up = tx_fail & retry_limit_enable_r &
        ((retry_limit_sel_r == CTQ_RETRY_NONE) |
        ((retry_limit_sel_r == CTQ_RETRY_THREE) & (fail_cnt_r == CTQ_THREE_RETRIES)));
    assign pop = tx_req.valid & (tx_done | give_up);
    // Advancing a full queue is ignored so the count stays honest
    assign push = adv_req & ~config_mode & ~queue_clear_r & queue_not_full_flag;
    assign obj_bytes = CTQ_HDR_BYTES + payload_bytes(payload_bytes_sel_r);
    // Largest offset is 31 objects of 72 bytes, well inside twelve bits
    assign obj_offset = 12'(tail_r * obj_bytes);

    // Control register readback, unimplemented bits zero
    assign ctrl_rd = {payload_bytes_sel_r, queue_depth_sel_r, 1'b0, retry_limit_sel_r,
        send_priority_r, 5'h00, queue_clear_r, send_request_r, 1'b0, 1'b1, 2'h0,
        retries_exhausted_irq_en_r, 1'b0, queue_empty_irq_en_r, 1'b0,
        queue_not_full_irq_en_r};

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: read data captured in setup, answer in the access cycle
    //
    // The slave never stretches a transfer: pready rises in every access
    // cycle. Capturing read data at the setup edge costs nothing in latency
    // and keeps prdata a plain register output.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr != CTQ_OFS_BASE) & (paddr != CTQ_OFS_CTRL)
                & (paddr != CTQ_OFS_MODE) & (paddr != CTQ_OFS_STAT);
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                CTQ_OFS_BASE: prdata <= msg_mem_base_addr_r;
                CTQ_OFS_CTRL: prdata <= ctrl_rd;
                CTQ_OFS_MODE: prdata <= 32'({op_mode_state_r, 12'h000, retry_limit_enable_r,
                    8'h00});
                CTQ_OFS_STAT: prdata <= 32'({tail_r, 3'h0, retries_exhausted_r, 1'b0,
                    queue_empty_flag, 1'b0, queue_not_full_flag});
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    //
    // Writes that are not allowed in the present mode are dropped quietly,
    // field by field; other fields of the same word still land.

    // Base address, frozen outside configuration mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_mem_base_addr_r <= CTQ_BASE_RST;
        end else if (wr_en && paddr == CTQ_OFS_BASE && config_mode) begin
            msg_mem_base_addr_r <= pwdata & CTQ_BASE_MASK;
        end
    end

    // Mode mirror: op mode and retry limit enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode_state_r <= CTQ_OPMODE_RST;
            retry_limit_enable_r <= 1'b0;
        end else if (wr_en && paddr == CTQ_OFS_MODE) begin
            op_mode_state_r <= pwdata[CTQ_OPMODE_LSB +: 3];
            retry_limit_enable_r <= pwdata[CTQ_RLEN_BIT];
        end
    end

    // Sizing fields only move in configuration mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            payload_bytes_sel_r <= 3'h0;
            queue_depth_sel_r <= 5'h00;
        end else if (wr_ctrl && config_mode) begin
            payload_bytes_sel_r <= pwdata[CTQ_PLD_LSB +: 3];
            queue_depth_sel_r <= pwdata[CTQ_DEPTH_LSB +: 5];
        end
    end

    // Fields writable in any mode, so a bus-off node can be re-armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry_limit_sel_r <= CTQ_RETRY_RST;
            send_priority_r <= 5'h00;
            retries_exhausted_irq_en_r <= 1'b0;
            queue_empty_irq_en_r <= 1'b0;
            queue_not_full_irq_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            retry_limit_sel_r <= pwdata[CTQ_RETRY_LSB +: 2];
            send_priority_r <= pwdata[CTQ_PRIO_LSB +: 5];
            retries_exhausted_irq_en_r <= pwdata[CTQ_ATIE_BIT];
            queue_empty_irq_en_r <= pwdata[CTQ_QEIE_BIT];
            queue_not_full_irq_en_r <= pwdata[CTQ_QNIE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue clear: held in configuration mode, one-cycle reset in normal mode
    //
    // The clear finishes in a single cycle, so software polling the bit sees
    // it low again on its next read. Pointers follow one edge after the bit.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_clear_r <= 1'b1;
        end else if (config_mode) begin
            queue_clear_r <= 1'b1;
        end else if (wr_ctrl && pwdata[CTQ_CLEAR_BIT]) begin
            queue_clear_r <= 1'b1;
        end else begin
            queue_clear_r <= 1'b0;
        end
    end

    // Head, tail and count; clear has priority over any traffic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_r <= 5'h00;
            tail_r <= 5'h00;
            count_r <= 6'h00;
        end else if (queue_clear_r) begin
            head_r <= 5'h00;
            tail_r <= 5'h00;
            count_r <= 6'h00;
        end else begin
            if (push) begin
                head_r <= ptr_inc(head_r, queue_depth_sel_r);
            end
            if (pop) begin
                tail_r <= ptr_inc(tail_r, queue_depth_sel_r);
            end
            if (push && !pop) begin
                count_r <= count_r + 6'h01;
            end else if (pop && !push) begin
                count_r <= count_r - 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Send request and abort
    //
    // Any control write with the send bit low while a send is pending is an
    // abort, including writes that only touch enables. Software must keep
    // the send bit high when it updates other fields during a send.

    // Set by software, cleared when the queue drains or on abort
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            send_request_r <= 1'b0;
            tx_abort <= 1'b0;
        end else begin
            tx_abort <= 1'b0;
            if (queue_clear_r) begin
                send_request_r <= 1'b0;
            end else if (wr_ctrl && pwdata[CTQ_SEND_BIT]) begin
                send_request_r <= 1'b1;
            end else if (wr_ctrl && send_request_r) begin
                send_request_r <= 1'b0;
                tx_abort <= 1'b1;
            end else if (send_request_r && (queue_empty_flag ||
                (pop && count_r == 6'h01 && !push))) begin
                send_request_r <= 1'b0;
            end
        end
    end

    // Failed attempts of the message at the tail
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_cnt_r <= 2'h0;
        end else if (queue_clear_r || pop) begin
            fail_cnt_r <= 2'h0;
        end else if (tx_fail && tx_req.valid && fail_cnt_r != CTQ_THREE_RETRIES) begin
            fail_cnt_r <= fail_cnt_r + 2'h1;
        end
    end

    // Sticky exhausted flag; a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retries_exhausted_r <= 1'b0;
        end else if (tx_req.valid && give_up) begin
            retries_exhausted_r <= 1'b1;
        end else if (wr_en && paddr == CTQ_OFS_STAT && pwdata[CTQ_EXH_BIT]) begin
            retries_exhausted_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request towards the transmit engine; priority 11111 wins arbitration
    //
    // Valid drops for at least one cycle after every pop, so the engine
    // never sees a stale address paired with a fresh valid.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_req <= '0;
        end else begin
            tx_req.valid <= send_request_r & ~queue_clear_r & ~pop & ~tx_abort
                & (count_r > (pop ? 6'h01 : 6'h00)) & ~(wr_ctrl & ~pwdata[CTQ_SEND_BIT]);
            tx_req.addr <= msg_mem_base_addr_r + 32'(obj_offset);
            tx_req.prio <= send_priority_r;
            tx_req.retry_sel <= retry_limit_enable_r ? retry_limit_sel_r : CTQ_RETRY_RST;
        end
    end

    // Interrupt from any enabled status flag
    // Level output; it follows the flags with one cycle of delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_irq <= 1'b0;
        end else begin
            queue_irq <= (retries_exhausted_r & retries_exhausted_irq_en_r)
                | (queue_empty_flag & queue_empty_irq_en_r)
                | (queue_not_full_flag & queue_not_full_irq_en_r);
        end
    end

endmodule // ctq_tx_queue

/* ctq_checker.sv */
`timescale 1ns/1ps
module ctq_checker
    import ctq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Transmit engine side
    input wire ctq_tx_req_s tx_req,
    input wire logic tx_abort,
    input wire logic tx_done,
    input wire logic tx_fail,
    input wire logic queue_irq
);
    // One clock domain, so clock and reset are given once here
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic rd_ctrl;
    // Accepted read of the queue control word
    assign rd_ctrl = pready && !pslverr && !pwrite && paddr == CTQ_OFS_CTRL;
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_after_setup:
        assert property (psel && !penable |=> pready) else $error("ready missing after setup");
    a_ready_single:
        assert property (pready |=> !pready) else $error("ready held too long");
    a_refused_zero:
        assert property (pslverr && !pwrite |-> pready && prdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_txdir_reads_one:
        assert property (rd_ctrl |-> prdata[CTQ_TXDIR_BIT]) else $error("direction bit low");
    a_unused_bits_zero:
        assert property (rd_ctrl |-> (prdata & 32'h0080_F96A) == 32'h0000_0000)
        else $error("unused control bits set");
    a_base_aligned:
        assert property (pready && !pwrite && paddr == CTQ_OFS_BASE |-> prdata[1:0] == 2'h0)
        else $error("base not word aligned");
    a_obj_aligned:
        assert property (tx_req.valid |-> tx_req.addr[1:0] == 2'h0) else $error("object misaligned");
    a_obj_addr_steady:
        assert property (tx_req.valid && $past(tx_req.valid) |-> $stable(tx_req.addr))
        else $error("object address moved");
    a_pop_drops_valid:
        assert property (tx_req.valid && tx_done |=> !tx_req.valid) else $error("valid kept after pop");
    a_abort_single:
        assert property (tx_abort |=> !tx_abort) else $error("abort longer than a pulse");
endmodule // ctq_checker

bind ctq_tx_queue ctq_checker ctq_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_req(tx_req), .tx_abort(tx_abort),
    .tx_done(tx_done), .tx_fail(tx_fail), .queue_irq(queue_irq));

/* ctq_tx_engine_model.sv */
`timescale 1ns/1ps
module ctq_tx_engine_model
    import ctq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Queue side
    input wire ctq_tx_req_s tx_req,
    input wire logic tx_abort,
    output logic tx_done,
    output logic tx_fail,
    // Scenario controls: frame length and failed attempts per message
    input wire logic [7:0] delay,
    input wire logic [2:0] fails
);
    logic [7:0] wait_r;
    logic [2:0] fail_r;
    // Each frame lasts delay plus one cycles, then fails until the budget is spent, then succeeds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 8'h00;
            fail_r <= 3'h0;
            tx_done <= 1'b0;
            tx_fail <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            tx_fail <= 1'b0;
            if (!tx_req.valid) begin
                fail_r <= 3'h0;
            end
            if (!tx_req.valid || tx_abort || tx_done || tx_fail) begin
                wait_r <= 8'h00;
            end else if (wait_r == delay) begin
                wait_r <= 8'h00;
                tx_fail <= fail_r < fails;
                tx_done <= fail_r >= fails;
                fail_r <= fail_r + 3'h1;
            end else begin
                wait_r <= wait_r + 8'h01;
            end
        end
    end
endmodule // ctq_tx_engine_model

/* ctq_tx_queue_tb.sv */
`timescale 1ns/1ps
module ctq_tx_queue_tb
    import ctq_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ctq_tx_req_s tx_req;
    logic tx_abort;
    logic tx_done;
    logic tx_fail;
    logic queue_irq;
    logic [7:0] delay = 8'h03;
    logic [2:0] fails = 3'h0;
    logic [31:0] last_addr = 32'h0000_0000;
    logic [1:0] sel_seen = 2'h0;
    logic [4:0] prio_seen = 5'h00;
    logic last_err;
    int n_fail = 0;
    int n_abort = 0;
    int mismatches = 0;
    int n_compared = 0;
    int pl[8] = '{8, 12, 16, 20, 24, 32, 48, 64};

    // 100 MHz clock
    always #5 pclk = ~pclk;

    ctq_tx_queue ctq_tx_queue_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_req(tx_req), .tx_abort(tx_abort),
        .tx_done(tx_done), .tx_fail(tx_fail), .queue_irq(queue_irq));
    ctq_tx_engine_model ctq_tx_engine_model_i (.pclk(pclk), .presetn(presetn), .tx_req(tx_req),
        .tx_abort(tx_abort), .tx_done(tx_done), .tx_fail(tx_fail), .delay(delay), .fails(fails));

    // Record what reached the engine, for the end-of-send comparisons
    always @(posedge pclk) begin
        if (tx_req.valid && tx_done) last_addr <= tx_req.addr;
        if (tx_req.valid) sel_seen <= tx_req.retry_sel;
        if (tx_req.valid) prio_seen <= tx_req.prio;
        if (tx_req.valid && tx_fail) n_fail <= n_fail + 1;
        if (tx_abort) n_abort <= n_abort + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; entered just after a rising edge, ends with an idle cycle
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No fixed wait state count is assumed; the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        apb(a, 1'b0, 32'h0000_0000, r);
        chk(nm, e, r);
    endtask

    // Bounded poll of one register bit; polling stands in for a completion handshake
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        logic [31:0] r;
        int n;
        n = 0;
        apb(a, 1'b0, 32'h0000_0000, r);
        while (r[b] !== v && n < 300) begin
            apb(a, 1'b0, 32'h0000_0000, r);
            n++;
        end
        chk("polled bit", {31'h0, v}, {31'h0, r[b]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under a tenth of this
    initial begin
        #200us;
        mismatches++;
        summarize();
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        int a0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTQ_OFS_CTRL, 32'h0060_0480, "ctrl reset");
        rd(CTQ_OFS_BASE, 32'h0000_0000, "base reset");
        rd(CTQ_OFS_STAT, 32'h0000_0005, "status reset");
        chk("irq reset", 32'h0, {31'h0, queue_irq});
        wr(CTQ_OFS_BASE, 32'h1234_5677);
        rd(CTQ_OFS_BASE, 32'h1234_5674, "base aligned");
        wr(CTQ_OFS_CTRL, 32'h21BF_FCFF);
        rd(CTQ_OFS_CTRL, 32'h213F_0495, "ctrl config");
        chk("irq enabled", 32'h1, {31'h0, queue_irq});
        wr(CTQ_OFS_MODE, 32'h0000_0000);
        rd(CTQ_OFS_CTRL, 32'h213F_0095, "clear in normal");
        wr(CTQ_OFS_BASE, 32'h0000_0000);
        rd(CTQ_OFS_BASE, 32'h1234_5674, "base locked");
        wr(CTQ_OFS_CTRL, 32'hE01F_0015);
        rd(CTQ_OFS_CTRL, 32'h211F_0095, "ctrl normal");
        // Every payload size, two-deep queue, third advance refused when full
        for (int i = 0; i < 8; i++) begin
            wr(CTQ_OFS_MODE, 32'h0080_0000);
            wr(CTQ_OFS_CTRL, {i[2:0], 29'h0160_0000});
            wr(CTQ_OFS_MODE, 32'h0000_0000);
            repeat (3) wr(CTQ_OFS_CTRL, 32'h0160_0100);
            rd(CTQ_OFS_STAT, 32'h0000_0000, "status full");
            wr(CTQ_OFS_CTRL, 32'h0160_0200);
            poll(CTQ_OFS_CTRL, CTQ_SEND_BIT, 1'b0);
            chk("object addr", 32'h1234_567C + 32'(pl[i]), last_addr);
            rd(CTQ_OFS_STAT, 32'h0000_0005, "status drained");
        end
        chk("retry sel off", 32'h3, {30'h0, sel_seen});
        // Limit enabled, three retries: the fourth failure drops the message
        fails <= 3'h4;
        wr(CTQ_OFS_MODE, 32'h0000_0100);
        wr(CTQ_OFS_CTRL, 32'h003F_0110);
        wr(CTQ_OFS_CTRL, 32'h003F_0210);
        poll(CTQ_OFS_STAT, CTQ_EXH_BIT, 1'b1);
        chk("fail count", 32'd4, 32'(n_fail));
        chk("retry sel", 32'h1, {30'h0, sel_seen});
        chk("priority", 32'h1F, {27'h0, prio_seen});
        chk("irq exhausted", 32'h1, {31'h0, queue_irq});
        // Queue clear in normal mode, then abort a slow frame
        fails <= 3'h0;
        delay <= 8'd200;
        wr(CTQ_OFS_STAT, 32'h0000_0010);
        wr(CTQ_OFS_CTRL, 32'h0000_0400);
        poll(CTQ_OFS_CTRL, CTQ_CLEAR_BIT, 1'b0);
        rd(CTQ_OFS_STAT, 32'h0000_0005, "status cleared");
        wr(CTQ_OFS_CTRL, 32'h0000_0100);
        wr(CTQ_OFS_CTRL, 32'h0000_0200);
        a0 = n_abort;
        wr(CTQ_OFS_CTRL, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk("abort pulses", 32'(a0 + 1), 32'(n_abort));
        chk("valid after abort", 32'h0, {31'h0, tx_req.valid});
        apb(8'h10, 1'b0, 32'h0000_0000, r);
        chk("unmapped data", 32'h0, r);
        chk("unmapped err", 32'h1, {31'h0, last_err});
        summarize();
    end
endmodule // ctq_tx_queue_tb
